// >>> core/mfpt_pin_ctrl.sv
`timescale 1ns/1ps
`include "mfpt_regs.svh"

module mfpt_pin_ctrl (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe_n,
  input  wire logic        nvm_busy,
  input  wire logic [3:0]  dac_busy,
  input  wire logic [3:0]  win_cmp,
  output logic             deep_sleep,
  output logic      [3:0]  current_output_pdn,
  output logic      [3:0]  voltage_output_pdn,
  output logic      [7:0]  voltage_pulldown_select,
  output logic             snapshot_pulse,
  output logic             protect_pulse,
  output logic             clear_action_pulse,
  output logic             device_reset_pulse,
  output logic             nvm_program_pulse
);
  // ****************************************************
  // declarations
  // ****************************************************
  mfpt_pkg::mfpt_state_t state;
  logic [`MFPT_CFG_W-1:0] cfg;
  logic [`MFPT_CFG_W-1:0] nv_cfg;
  logic [1:0]             settle;
  logic                   write_lock;
  logic                   nvm_lock;
  logic                   pin_level;
  logic                   pin_rose;
  logic                   pin_fell;
  logic                   run;
  logic                   fall_ev;
  logic                   rise_ev;
  logic                   wr_ok;
  logic                   cfg_wr;
  logic                   ctl_wr;
  logic                   key_wr;
  logic                   rst_req;
  logic [3:0]             chan_sel;

  // true when the configuration maps the pin input to code
  function automatic logic fn_mapped(
    input logic [`MFPT_CFG_W-1:0] c,
    input logic [3:0]             code
  );
    return c[`MFPT_CFG_IN_EN] && c[`MFPT_CFG_IN_FN +: 4] == code;
  endfunction

  // per-channel power state after a pin edge
  function automatic logic [3:0] pdn_next(
    input logic [3:0] cur,
    input logic [3:0] sel,
    input logic       fall,
    input logic       rise
  );
    logic [3:0] r;
    r = cur;
    if (fall)
      r = cur | sel;
    else if (rise)
      r = cur & ~sel;
    return r;
  endfunction

  // ****************************************************
  // pin synchroniser
  // ****************************************************
  mfpt_pin_sync u_sync (
    .clk       (clk),
    .rstn      (rstn),
    .pin_async (pin_in),
    .level     (pin_level),
    .rose      (pin_rose),
    .fell      (pin_fell)
  );

  // ****************************************************
  // pin events and write decode
  // ****************************************************
  // boot turns the settled level into a pseudo edge, run uses edges
  assign run      = state == mfpt_pkg::RUN;
  assign fall_ev  = (run & pin_fell) |
                    (state == mfpt_pkg::BOOT_APPLY & ~pin_level);
  assign rise_ev  = (run & pin_rose) |
                    (state == mfpt_pkg::BOOT_APPLY & pin_level);
  assign chan_sel = cfg[`MFPT_CFG_SEL +: 4];
  // locked map still takes the unlock key and the reset field
  assign wr_ok    = wr & (~write_lock | addr == `MFPT_ADDR_KEY);
  assign cfg_wr   = wr_ok & addr == `MFPT_ADDR_CFG;
  assign ctl_wr   = wr_ok & addr == `MFPT_ADDR_CTRL;
  assign key_wr   = wr_ok & addr == `MFPT_ADDR_KEY;
  // pin reset only counts when nonvolatile copy holds it too
  assign rst_req  = (run & pin_fell & fn_mapped(cfg, `MFPT_FN_RST) &
                    fn_mapped(nv_cfg, `MFPT_FN_RST)) |
                    (key_wr & wdata[`MFPT_KEY_RST]);

  // ****************************************************
  // boot sequencer
  // ****************************************************
  // settle wait lets the synchroniser carry the real level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state  <= mfpt_pkg::BOOT_LOAD;
      settle <= 2'h0;
    end else if (rst_req) begin
      state  <= mfpt_pkg::BOOT_LOAD;
      settle <= 2'h0;
    end else begin
      unique case (state)
        mfpt_pkg::BOOT_LOAD: begin
          state  <= mfpt_pkg::BOOT_SETTLE;
          settle <= 2'h0;
        end
        mfpt_pkg::BOOT_SETTLE: begin
          settle <= settle + 2'h1;
          if (settle == `MFPT_SETTLE - 2'h1)
            state <= mfpt_pkg::BOOT_APPLY;
        end
        mfpt_pkg::BOOT_APPLY: state <= mfpt_pkg::RUN;
        mfpt_pkg::RUN:        state <= mfpt_pkg::RUN;
      endcase
    end
  end

  // ****************************************************
  // pin configuration, volatile and stored copies
  // ****************************************************
  // a device reset reloads only what was stored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      cfg <= `MFPT_CFG_RESET;
    else if (state == mfpt_pkg::BOOT_LOAD)
      cfg <= nv_cfg;
    else if (cfg_wr)
      cfg <= wdata[`MFPT_CFG_W-1:0];
  end

  // programming needs idle array and open nvm and write locks;
  // the key register is reachable while locked, so its program bit
  // must be gated here or a locked map could still be stored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nv_cfg            <= `MFPT_CFG_RESET;
      nvm_program_pulse <= 1'b0;
    end else begin
      nvm_program_pulse <= 1'b0;
      if (key_wr && wdata[`MFPT_KEY_PROG] && !nvm_lock && !nvm_busy
          && !write_lock) begin
        nv_cfg            <= cfg;
        nvm_program_pulse <= 1'b1;
      end
    end
  end

  // ****************************************************
  // deep sleep, all channels
  // ****************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      deep_sleep <= 1'b0;
    else if (rst_req)
      deep_sleep <= 1'b0;
    else if (fn_mapped(cfg, `MFPT_FN_SLEEP)) begin
      if (fall_ev)
        deep_sleep <= 1'b1;
      else if (rise_ev)
        deep_sleep <= 1'b0;
    end else if (ctl_wr)
      deep_sleep <= wdata[`MFPT_CTL_SLEEP];
  end

  // ****************************************************
  // output power-down per channel
  // ****************************************************
  // power changes are refused in deep sleep from either source
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      current_output_pdn <= 4'h0;
    else if (rst_req)
      current_output_pdn <= 4'h0;
    else if (fn_mapped(cfg, `MFPT_FN_CURRENT_OUTPUT)) begin
      if (!deep_sleep)
        current_output_pdn <= pdn_next(current_output_pdn,
                                       chan_sel, fall_ev, rise_ev);
    end else if (ctl_wr && !deep_sleep)
      current_output_pdn <= wdata[`MFPT_CTL_CURRENT_OUTPUT +: 4];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      voltage_output_pdn <= 4'h0;
    else if (rst_req)
      voltage_output_pdn <= 4'h0;
    else if (fn_mapped(cfg, `MFPT_FN_VOLTAGE_OUTPUT)) begin
      if (!deep_sleep)
        voltage_output_pdn <= pdn_next(voltage_output_pdn,
                                       chan_sel, fall_ev, rise_ev);
    end else if (ctl_wr && !deep_sleep)
      voltage_output_pdn <= wdata[`MFPT_CTL_VOLTAGE_OUTPUT +: 4];
  end

  // pulldown choice applies whenever a voltage output is down
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      voltage_pulldown_select <= 8'h00;
    else if (rst_req)
      voltage_pulldown_select <= 8'h00;
    else if (wr_ok && addr == `MFPT_ADDR_PULL)
      voltage_pulldown_select <= wdata[7:0];
  end

  // ****************************************************
  // device-wide trigger pulses
  // ****************************************************
  // falling edge only; a rising edge has no effect for these codes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      snapshot_pulse     <= 1'b0;
      protect_pulse      <= 1'b0;
      clear_action_pulse <= 1'b0;
    end else begin
      snapshot_pulse     <= !deep_sleep && !rst_req &&
        (fn_mapped(cfg, `MFPT_FN_SNAP) ? fall_ev
         : ctl_wr && wdata[`MFPT_CTL_SNAP]);
      protect_pulse      <= !deep_sleep && !rst_req &&
        (fn_mapped(cfg, `MFPT_FN_PROT) ? fall_ev
         : ctl_wr && wdata[`MFPT_CTL_PROT]);
      clear_action_pulse <= !deep_sleep && !rst_req &&
        (fn_mapped(cfg, `MFPT_FN_CLR) ? fall_ev
         : ctl_wr && wdata[`MFPT_CTL_CLR]);
    end
  end

  // stays high for one cycle, the sequencer reboots meanwhile
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      device_reset_pulse <= 1'b0;
    else
      device_reset_pulse <= rst_req;
  end

  // ****************************************************
  // write and nvm locks
  // ****************************************************
  // key write clears the write lock unless the pin owns it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      write_lock <= 1'b0;
    else if (rst_req)
      write_lock <= 1'b0;
    else if (fn_mapped(cfg, `MFPT_FN_WLOCK)) begin
      if (fall_ev)
        write_lock <= 1'b0;
      else if (rise_ev)
        write_lock <= 1'b1;
    end else if (ctl_wr && wdata[`MFPT_CTL_WLOCK])
      write_lock <= 1'b1;
    else if (key_wr && wdata[`MFPT_KEY_UNLOCK +: 4] == `MFPT_UNLOCK_KEY)
      write_lock <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      nvm_lock <= 1'b0;
    else if (rst_req)
      nvm_lock <= 1'b0;
    else if (fn_mapped(cfg, `MFPT_FN_NLOCK)) begin
      if (fall_ev)
        nvm_lock <= 1'b0;
      else if (rise_ev)
        nvm_lock <= 1'b1;
    end else if (ctl_wr)
      nvm_lock <= wdata[`MFPT_CTL_NLOCK];
  end

  // ****************************************************
  // pin output driver
  // ****************************************************
  // input enable wins, so the pin never fights its own driver
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      pin_oe_n <= !(cfg[`MFPT_CFG_OUT_EN] && !cfg[`MFPT_CFG_IN_EN]);
      unique case (cfg[`MFPT_CFG_OUT_FN+2 +: 2])
        2'h0: pin_out <= cfg[`MFPT_CFG_OUT_FN +: 4] == `MFPT_ST_NVM
                         && nvm_busy;
        `MFPT_ST_BUSY: pin_out <= dac_busy[cfg[`MFPT_CFG_OUT_FN +: 2]];
        `MFPT_ST_WIN:  pin_out <= win_cmp[cfg[`MFPT_CFG_OUT_FN +: 2]];
        default:       pin_out <= 1'b0;
      endcase
    end
  end

  // ****************************************************
  // register read
  // ****************************************************
  // data valid only in the cycle after the read strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      rdata <= 32'h0000_0000;
    else if (!rd)
      rdata <= 32'h0000_0000;
    else begin
      unique case (addr)
        `MFPT_ADDR_CFG:   rdata <= {18'h0, cfg};
        `MFPT_ADDR_NVCFG: rdata <= {18'h0, nv_cfg};
        `MFPT_ADDR_PULL:  rdata <= {24'h0, voltage_pulldown_select};
        `MFPT_ADDR_CTRL, `MFPT_ADDR_STAT:
          rdata <= {16'h0, run, pin_level, nvm_lock, write_lock,
                    3'h0, voltage_output_pdn, current_output_pdn,
                    deep_sleep};
        default:          rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  pin_drive_a: assert property (@(posedge clk) disable iff (!rstn)
    cfg[`MFPT_CFG_OUT_EN] && !cfg[`MFPT_CFG_IN_EN] |=> !pin_oe_n)
    else $error("pin not driven with output enabled");

  unmapped_boot_a: assert property (@(posedge clk) disable iff (!rstn)
    state == mfpt_pkg::BOOT_LOAD && nv_cfg == `MFPT_CFG_RESET
    |=> cfg == `MFPT_CFG_RESET ##1 pin_oe_n)
    else $error("pin mapped after default boot");

  boot_level_a: assert property (@(posedge clk) disable iff (!rstn)
    state == mfpt_pkg::BOOT_APPLY && !pin_level && !rst_req
    && fn_mapped(cfg, `MFPT_FN_SLEEP) |=> deep_sleep)
    else $error("boot level not applied");

  sleep_edge_a: assert property (@(posedge clk) disable iff (!rstn)
    run && pin_rose && fn_mapped(cfg, `MFPT_FN_SLEEP) && !rst_req
    |=> !deep_sleep)
    else $error("rising edge did not wake");

  current_output_sel_a: assert property (@(posedge clk) disable iff (!rstn)
    run && pin_fell && fn_mapped(cfg, `MFPT_FN_CURRENT_OUTPUT) && !deep_sleep
    && !rst_req |=> (current_output_pdn & $past(chan_sel))
    == $past(chan_sel))
    else $error("selected current outputs not down");

  steady_level_a: assert property (@(posedge clk) disable iff (!rstn)
    run && !pin_rose && !pin_fell && !wr && fn_mapped(cfg, `MFPT_FN_VOLTAGE_OUTPUT)
    |=> $stable(voltage_output_pdn))
    else $error("steady level changed power state");

  sw_ignored_a: assert property (@(posedge clk) disable iff (!rstn)
    ctl_wr && fn_mapped(cfg, `MFPT_FN_SLEEP) && !fall_ev && !rise_ev
    && !rst_req |=> $stable(deep_sleep))
    else $error("software bit acted while pin mapped");

  clear_fall_a: assert property (@(posedge clk) disable iff (!rstn)
    run && pin_fell && fn_mapped(cfg, `MFPT_FN_CLR) && !deep_sleep
    && !rst_req |=> clear_action_pulse ##1 !clear_action_pulse)
    else $error("clear not pulsed on falling edge");

  pin_reset_a: assert property (@(posedge clk) disable iff (!rstn)
    run && pin_fell && fn_mapped(cfg, `MFPT_FN_RST)
    && fn_mapped(nv_cfg, `MFPT_FN_RST)
    |=> device_reset_pulse && state == mfpt_pkg::BOOT_LOAD)
    else $error("pin reset not started");

  volatile_reset_a: assert property (@(posedge clk) disable iff (!rstn)
    run && pin_fell && fn_mapped(cfg, `MFPT_FN_RST) && !wr
    && !fn_mapped(nv_cfg, `MFPT_FN_RST) |=> !device_reset_pulse)
    else $error("unstored reset mapping acted");

  write_block_a: assert property (@(posedge clk) disable iff (!rstn)
    run && write_lock && wr && addr == `MFPT_ADDR_CFG |=> $stable(cfg))
    else $error("locked write reached configuration");
endmodule // mfpt_pin_ctrl

// >>> core/mfpt_pin_sync.sv
`timescale 1ns/1ps
`include "mfpt_regs.svh"

module mfpt_pin_sync (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic pin_async,
  output logic      level,
  output logic      rose,
  output logic      fell
);
  logic meta;
  logic prev;

  // ****************************************************
  // two-stage synchroniser, edges taken after stage two
  // ****************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta  <= `MFPT_PIN_IDLE;
      level <= `MFPT_PIN_IDLE;
      prev  <= `MFPT_PIN_IDLE;
    end else begin
      meta  <= pin_async;
      level <= meta;
      prev  <= level;
    end
  end

  // edges are one-cycle pulses in the clk domain
  assign rose = level & ~prev;
  assign fell = ~level & prev;
endmodule // mfpt_pin_sync

// >>> core/mfpt_pkg.sv
package mfpt_pkg;
  // boot sequence and normal running
  typedef enum logic [1:0] {
    BOOT_LOAD,
    BOOT_SETTLE,
    BOOT_APPLY,
    RUN
  } mfpt_state_t;
endpackage

// >>> core/mfpt_regs.svh
`ifndef MFPT_REGS_SVH
`define MFPT_REGS_SVH

// ****************************************************
// register offsets
// ****************************************************
`define MFPT_ADDR_CFG    8'h00
`define MFPT_ADDR_CTRL   8'h04
`define MFPT_ADDR_STAT   8'h08
`define MFPT_ADDR_PULL   8'h0C
`define MFPT_ADDR_KEY    8'h10
`define MFPT_ADDR_NVCFG  8'h14

// ****************************************************
// pin configuration fields
// ****************************************************
`define MFPT_CFG_IN_EN   0
`define MFPT_CFG_OUT_EN  1
`define MFPT_CFG_SEL     2
`define MFPT_CFG_IN_FN   6
`define MFPT_CFG_OUT_FN  10
`define MFPT_CFG_W       14
`define MFPT_CFG_RESET   14'h0000

// ****************************************************
// software control fields
// ****************************************************
`define MFPT_CTL_SLEEP   0
`define MFPT_CTL_CURRENT_OUTPUT    1
`define MFPT_CTL_VOLTAGE_OUTPUT    5
`define MFPT_CTL_SNAP    9
`define MFPT_CTL_PROT    10
`define MFPT_CTL_CLR     11
`define MFPT_CTL_WLOCK   12
`define MFPT_CTL_NLOCK   13

// ****************************************************
// key register fields
// ****************************************************
`define MFPT_KEY_UNLOCK  0
`define MFPT_KEY_RST     4
`define MFPT_KEY_PROG    5
`define MFPT_UNLOCK_KEY  4'hA

// ****************************************************
// input function codes
// ****************************************************
`define MFPT_FN_SLEEP    4'h0
`define MFPT_FN_SNAP     4'h2
`define MFPT_FN_CURRENT_OUTPUT     4'h3
`define MFPT_FN_VOLTAGE_OUTPUT     4'h4
`define MFPT_FN_PROT     4'h5
`define MFPT_FN_CLR      4'h7
`define MFPT_FN_RST      4'hB
`define MFPT_FN_NLOCK    4'hC
`define MFPT_FN_WLOCK    4'hD

// ****************************************************
// output function codes and timing
// ****************************************************
`define MFPT_ST_NVM      4'h1
`define MFPT_ST_BUSY     2'h1
`define MFPT_ST_WIN      2'h2
`define MFPT_SETTLE      2'h3
`define MFPT_PIN_IDLE    1'b1

`endif

// >>> verif/mfpt_pin_ctrl_bench.sv
`timescale 1ns/1ps
`include "mfpt_regs.svh"

module mfpt_pin_ctrl_bench;
  logic        clk, rstn, wr, rd, nvm_busy, pin_lvl, pin_out, pin_oe_n;
  logic        deep_sleep;
  logic [7:0]  addr, pdsel, pdsel_o;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  dac_busy, win_cmp, cpdn, vpdn, sel, code;
  wire  [4:0]  pulses;
  logic [3:0]  odd [7] = '{4'h1, 4'h6, 4'h8, 4'h9, 4'hA, 4'hE, 4'hF};
  int          cnt [5] = '{0, 0, 0, 0, 0};
  int          n_mismatch, num_checks, base;

  mfpt_pin_ctrl dut (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pin_in(pin_lvl), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .nvm_busy(nvm_busy), .dac_busy(dac_busy),
    .win_cmp(win_cmp), .deep_sleep(deep_sleep),
    .current_output_pdn(cpdn), .voltage_output_pdn(vpdn),
    .voltage_pulldown_select(pdsel_o), .snapshot_pulse(pulses[0]),
    .protect_pulse(pulses[1]), .clear_action_pulse(pulses[2]),
    .device_reset_pulse(pulses[3]), .nvm_program_pulse(pulses[4])
  );

  mfpt_pin_driver drv (
    .clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_level(pin_lvl)
  );

  // ****************************************************
  // clock, pulse counting, shared tasks
  // ****************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // pulses last one cycle, so count them rather than poll
  always @(posedge clk)
    for (int i = 0; i < 5; i++)
      if (pulses[i] === 1'b1) cnt[i]++;

  task automatic chk(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // settle margin after the write lands before anyone looks
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // sync plus edge flop plus action register: 4 cycles is ample
  task automatic pin(input logic lvl);
    drv.put(lvl);
    #1;
  endtask

  function automatic logic [31:0] cfg(input logic [3:0] fn, s);
    return {18'h0, 4'h0, fn, s, 2'b01};
  endfunction

  function automatic logic exp_st(input logic [3:0] c);
    case (c[3:2])
      2'h1: return dac_busy[c[1:0]];
      2'h2: return win_cmp[c[1:0]];
      default: return (c == 4'h1) ? nvm_busy : 1'b0;
    endcase
  endfunction

  // hang guard, well above the roughly 500 cycles needed
  initial begin
    #(25 * 20000);
    n_mismatch++;
    conclude();
  end

  // ****************************************************
  // scenarios
  // ****************************************************
  initial begin
    void'($urandom(61));
    {rstn, wr, rd, nvm_busy} = 4'h0;
    addr = 8'h00;
    wdata = 32'h0;
    dac_busy = 4'h0;
    win_cmp = 4'h0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    rreg(`MFPT_ADDR_CFG, v);
    chk("cfg after reset", v, 32'h0);
    chk("pin_oe_n after reset", pin_oe_n, 1'b1);
    rreg(8'h20, v);
    chk("unmapped read", v, 32'h0);
    // sleep mapping, software sleep bit must be ignored
    wreg(`MFPT_ADDR_CFG, cfg(`MFPT_FN_SLEEP, 4'h0));
    pin(1'b0);
    chk("sleep on fall", deep_sleep, 1'b1);
    pin(1'b1);
    chk("wake on rise", deep_sleep, 1'b0);
    wreg(`MFPT_ADDR_CTRL, 32'h1);
    chk("owned sleep bit", deep_sleep, 1'b0);
    // device-wide pulses: fall fires once, rise adds nothing
    for (int k = 0; k < 3; k++) begin
      code = k == 0 ? `MFPT_FN_SNAP : k == 1 ? `MFPT_FN_PROT : `MFPT_FN_CLR;
      wreg(`MFPT_ADDR_CFG, cfg(code, 4'h0));
      base = cnt[k];
      pin(1'b0);
      chk("pulse on fall", 32'(cnt[k] - base), 32'h1);
      pin(1'b1);
      chk("pulse on rise", 32'(cnt[k] - base), 32'h1);
    end
    // codes without an action do nothing on either edge
    foreach (odd[i]) begin
      wreg(`MFPT_ADDR_CFG, cfg(odd[i], 4'hF));
      base = cnt.sum();
      pin(1'b0);
      pin(1'b1);
      chk("unlisted code", {deep_sleep, cpdn, vpdn}, 32'h0);
      chk("unlisted pulses", 32'(cnt.sum() - base), 32'h0);
    end
    // unowned software trigger bits each fire one pulse
    base = cnt.sum();
    wreg(`MFPT_ADDR_CTRL, 32'hE00);
    chk("software pulses", 32'(cnt.sum() - base), 32'h3);
    // per-channel power-down, the fixed mask 4'h5 then a random one
    for (int k = 0; k < 2; k++) begin
      sel = k ? 4'($urandom) : 4'h5;
      pdsel = 8'($urandom);
      wreg(`MFPT_ADDR_PULL, {24'h0, pdsel});
      wreg(`MFPT_ADDR_CFG, cfg(`MFPT_FN_CURRENT_OUTPUT, sel));
      pin(1'b0);
      chk("current_output down", cpdn, sel);
      wreg(`MFPT_ADDR_CTRL, 32'h1E);
      chk("owned current_output bits", cpdn, sel);
      pin(1'b1);
      chk("current_output up", cpdn, 4'h0);
      wreg(`MFPT_ADDR_CFG, cfg(`MFPT_FN_VOLTAGE_OUTPUT, sel));
      pin(1'b0);
      chk("voltage_output down", vpdn, sel);
      chk("pulldown select", pdsel_o, pdsel);
      pin(1'b1);
      chk("voltage_output up", vpdn, 4'h0);
    end
    // deep sleep blocks a pin power-down, as it does for software
    wreg(`MFPT_ADDR_CFG, cfg(`MFPT_FN_CURRENT_OUTPUT, 4'hF));
    wreg(`MFPT_ADDR_CTRL, 32'h1);
    pin(1'b0);
    chk("pdn in sleep", cpdn, 4'h0);
    wreg(`MFPT_ADDR_CTRL, 32'h0);
    pin(1'b1);
    // register write lock by pin, then release
    wreg(`MFPT_ADDR_CFG, cfg(`MFPT_FN_WLOCK, 4'h0));
    pin(1'b0);
    pin(1'b1);
    wreg(`MFPT_ADDR_CFG, cfg(`MFPT_FN_SLEEP, 4'h0));
    rreg(`MFPT_ADDR_CFG, v);
    chk("locked cfg", v, cfg(`MFPT_FN_WLOCK, 4'h0));
    wreg(`MFPT_ADDR_PULL, 32'h3C);
    rreg(`MFPT_ADDR_PULL, v);
    chk("locked write", v, {24'h0, pdsel});
    pin(1'b0);
    wreg(`MFPT_ADDR_PULL, 32'h3C);
    rreg(`MFPT_ADDR_PULL, v);
    chk("unlocked write", v, 32'h3C);
    // nonvolatile programming lock by pin
    wreg(`MFPT_ADDR_CFG, cfg(`MFPT_FN_NLOCK, 4'h0));
    pin(1'b1);
    base = cnt[4];
    wreg(`MFPT_ADDR_KEY, 32'h20);
    chk("program blocked", 32'(cnt[4] - base), 32'h0);
    pin(1'b0);
    wreg(`MFPT_ADDR_KEY, 32'h20);
    chk("program allowed", 32'(cnt[4] - base), 32'h1);
    rreg(`MFPT_ADDR_NVCFG, v);
    chk("stored copy", v, cfg(`MFPT_FN_NLOCK, 4'h0));
    // software write lock blocks programming, the key opens it
    wreg(`MFPT_ADDR_CTRL, 32'h1000);
    rreg(`MFPT_ADDR_STAT, v);
    chk("software lock", v[12], 1'b1);
    base = cnt[4];
    wreg(`MFPT_ADDR_KEY, 32'h20);
    chk("program while locked", 32'(cnt[4] - base), 32'h0);
    wreg(`MFPT_ADDR_KEY, 32'hA);
    rreg(`MFPT_ADDR_STAT, v);
    chk("key unlock", v[12], 1'b0);
    // reset mapping acts only once it is stored
    wreg(`MFPT_ADDR_CFG, cfg(`MFPT_FN_RST, 4'h0));
    pin(1'b1);
    pin(1'b0);
    chk("volatile reset map", 32'(cnt[3]), 32'h0);
    pin(1'b1);
    wreg(`MFPT_ADDR_KEY, 32'h20);
    pin(1'b0);
    pin(1'b1);
    chk("pin reset", 32'(cnt[3]), 32'h1);
    repeat (8) @(posedge clk);
    rreg(`MFPT_ADDR_CFG, v);
    chk("stored map kept", v, cfg(`MFPT_FN_RST, 4'h0));
    // boot applies the static low level of a stored sleep map
    wreg(`MFPT_ADDR_CFG, cfg(`MFPT_FN_SLEEP, 4'h0));
    wreg(`MFPT_ADDR_KEY, 32'h20);
    pin(1'b0);
    wreg(`MFPT_ADDR_KEY, 32'h10);
    repeat (8) @(posedge clk);
    chk("boot level action", deep_sleep, 1'b1);
    pin(1'b1);
    // status output for every code; input enable wins over output
    for (int c = 0; c < 16; c++) begin
      @(posedge clk);
      nvm_busy <= 1'($urandom);
      dac_busy <= 4'($urandom);
      win_cmp <= 4'($urandom);
      wreg(`MFPT_ADDR_CFG, {18'h0, 4'(c), 10'h002});
      chk("pin drive", pin_oe_n, 1'b0);
      chk("pin status", pin_out, exp_st(4'(c)));
    end
    wreg(`MFPT_ADDR_CFG, {18'h0, 4'h1, 10'h003});
    chk("input beats output", pin_oe_n, 1'b1);
    conclude();
  end
endmodule // mfpt_pin_ctrl_bench

// >>> verif/mfpt_pin_driver.sv
`timescale 1ns/1ps

// ****************************************************
// outside circuit on the multifunction pin
// ****************************************************
module mfpt_pin_driver (
  input  wire logic clk,
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  output logic      pin_level
);
  logic drive;

  // device drive wins; otherwise our level, idle high like a pull-up
  assign pin_level = !pin_oe_n ? pin_out : drive;

  initial drive = 1'b1;

  // a level is held 4 cycles so the two-flop sync cannot miss it
  task automatic put(input logic lvl);
    @(posedge clk);
    drive <= lvl;
    repeat (4) @(posedge clk);
  endtask
endmodule // mfpt_pin_driver
